// ==== dlc_alarm_status.sv ====
// module: alarm status bits, latched or following
`timescale 1ns/10ps
module dlc_alarm_status
   import dlc_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // conditions and control
   input wire logic [NST-1:0] i_cond,
   input wire logic i_read_clear,
   input wire logic i_latch_dis,
   // status
   output logic [NST-1:0] o_status
);

   // set wins over the read clear in latched mode
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_status <= NST'(RST_REG);
      end else if (i_latch_dis) begin
         o_status <= i_cond;
      end else begin
         o_status <= (o_status & ~{NST{i_read_clear}}) | i_cond;
      end
   end

endmodule : dlc_alarm_status

// ==== dlc_ctrl.sv ====
// module: dac load/clear control and alarm logic behind an axi4-lite slave
//
// Contract
// - reset zeroes data registers, latches, output codes
// - output buffers stay powered down until enabled
// - async mode: write loads latch immediately
// - sync mode: write changes only data register
// - load trigger copies data into sync latches
// - trigger reloads only channels written since last
// - entering clear loads latch with clear code
// - leaving clear reloads latch from data register
// - each clear pin has per-channel mask
// - software clear register clears selected channels
// - auto-clear source and channel enable registers
// - overtemp status, source bit 2 clears enables
// - overtemp protection off while local sensor down
// - out-of-range source sets its status bit
// - global alarm is OR of status bits
// - latched bits clear on status read only
// - latch disabled: bits follow their condition
// - alarm pin driven low while alarm active
// - input alarm outside low/high threshold window
// - each temp sensor has high and low bits
// - data read returns latch, not data register
// - only enabled sources drive alarm pin
//
// Our own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/10ps
module dlc_ctrl
   import dlc_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // axi4-lite write channels
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [7:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   // axi4-lite read channels
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [7:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   // monitor results and clear pins
   input wire dlc_adc_t i_adc,
   input wire dlc_temp_t i_temp,
   input wire logic i_clear_pin_a_n,
   input wire logic i_clear_pin_b_n,
   // dac and alarm outputs
   output dlc_code_t o_dac_code,
   output logic [NCH-1:0] o_buf_enable,
   output logic o_alarm_o,
   output logic o_alarm_oe
);

   // ****************************************
   // declarations
   // ****************************************
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic aw_have;
   logic w_have;
   logic alarm_latch_disable;
   logic local_temp_sensor;
   logic load_trigger_bit;
   logic [NCH-1:0] chan_load_mode;
   logic [NCH-1:0] pin_a_clear_mask;
   logic [NCH-1:0] pin_b_clear_mask;
   logic [NCH-1:0] software_clear_select;
   logic [15:0] auto_clear_source_sel;
   logic [15:0] auto_clear_chan_enable;
   logic [NST-1:0] alarm_source_enable;
   logic [NST-1:0] status;
   logic [NADC-1:0] adc_cond;
   logic [NCH-1:0] clr_prev;
   dlc_code_t clear_code;
   dlc_code_t chan_data;
   logic [NCH-1:0] chan_pending;
   logic [NCH-1:0] wr_ch;
   dlc_code_t wr_val;
   logic [NTHR-1:0][DW-1:0] thr;
   logic [31:0] rd_word;
   logic rd_ok;

   // register region decode, shared by writes and reads
   function automatic logic in_region(input logic [7:0] a, input logic [1:0] r, input int n);
      return (a[7:6] == r) && (int'(a[5:2]) < n);
   endfunction : in_region

   // bus write merged over an old value
   function automatic logic [31:0] mrg(input logic [31:0] old);
      return dlc_merge(old, w_data, w_strb);
   endfunction : mrg

   // ****************************************
   // axi4-lite handshakes
   // ****************************************
   wire aw_hs = i_awvalid && o_awready;
   wire w_hs = i_wvalid && o_wready;
   wire ar_hs = i_arvalid && o_arready;
   wire do_write = aw_have && w_have && !o_bvalid;
   wire wr_known = (aw_addr <= OFF_STATUS && aw_addr[1:0] == 2'h0) || in_region(aw_addr, REG_DATA, NCH)
                   || in_region(aw_addr, REG_CODE, NCH) || in_region(aw_addr, REG_THR, NTHR);

   // address and data holding, taken in either order
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
      end else begin
         if (aw_hs) begin
            aw_addr <= i_awaddr;
         end
         if (w_hs) begin
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end
         aw_have <= aw_hs || (aw_have && !do_write);
         w_have <= w_hs || (w_have && !do_write);
      end
   end

   // ready and response flags
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_awready <= 1'b0;
         o_wready <= 1'b0;
         o_arready <= 1'b0;
         o_bvalid <= 1'b0;
         o_bresp <= RESP_OKAY;
         o_rvalid <= 1'b0;
         o_rdata <= 32'h00000000;
         o_rresp <= RESP_OKAY;
      end else begin
         o_awready <= !aw_hs && !aw_have && !o_bvalid;
         o_wready <= !w_hs && !w_have && !o_bvalid;
         o_arready <= !ar_hs && !o_rvalid;
         if (do_write) begin
            o_bvalid <= 1'b1;
            o_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
         end else if (i_bready) begin
            o_bvalid <= 1'b0;
         end
         if (ar_hs) begin
            o_rvalid <= 1'b1;
            o_rdata <= rd_word;
            o_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (i_rready) begin
            o_rvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // configuration registers
   // ****************************************
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         alarm_latch_disable <= 1'b0;
         local_temp_sensor <= 1'b0;
         chan_load_mode <= NCH'(RST_REG);
         o_buf_enable <= NCH'(RST_REG);
         pin_a_clear_mask <= NCH'(RST_REG);
         pin_b_clear_mask <= NCH'(RST_REG);
         software_clear_select <= NCH'(RST_REG);
         auto_clear_source_sel <= RST_REG;
         auto_clear_chan_enable <= RST_REG;
         alarm_source_enable <= NST'(RST_REG);
      end else if (do_write) begin
         case (aw_addr)
            OFF_CTRL: begin
               alarm_latch_disable <= w_strb[0] ? w_data[CTRL_LDIS] : alarm_latch_disable;
               local_temp_sensor <= w_strb[0] ? w_data[CTRL_LTPWR] : local_temp_sensor;
            end
            OFF_LOAD_MODE: chan_load_mode <= NCH'(mrg(32'(chan_load_mode)));
            OFF_BUF_EN: o_buf_enable <= NCH'(mrg(32'(o_buf_enable)));
            OFF_MASK_A: pin_a_clear_mask <= NCH'(mrg(32'(pin_a_clear_mask)));
            OFF_MASK_B: pin_b_clear_mask <= NCH'(mrg(32'(pin_b_clear_mask)));
            OFF_SW_CLR: software_clear_select <= NCH'(mrg(32'(software_clear_select)));
            OFF_AUTO_SRC: auto_clear_source_sel <= 16'(mrg(32'(auto_clear_source_sel)));
            OFF_AUTO_EN: auto_clear_chan_enable <= 16'(mrg(32'(auto_clear_chan_enable)));
            OFF_ALARM_EN: alarm_source_enable <= NST'(mrg(32'(alarm_source_enable)));
            default: ;
         endcase
      end
   end

   // clear codes, thresholds and the one-cycle load pulse
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         clear_code <= '0;
         thr <= '0;
         load_trigger_bit <= 1'b0;
      end else begin
         load_trigger_bit <= do_write && aw_addr == OFF_CTRL && w_strb[0] && w_data[CTRL_LOAD];
         if (do_write && in_region(aw_addr, REG_CODE, NCH)) begin
            clear_code[aw_addr[5:2]] <= DW'(mrg(32'(clear_code[aw_addr[5:2]])));
         end
         if (do_write && in_region(aw_addr, REG_THR, NTHR)) begin
            thr[aw_addr[4:2]] <= DW'(mrg(32'(thr[aw_addr[4:2]])));
         end
      end
   end

   // ****************************************
   // clear sources and dac channels
   // ****************************************
   wire overtemp_clear_source = status[ST_OVERTEMP] && auto_clear_source_sel[SRC_OVERTEMP] && local_temp_sensor;
   wire [NCH-1:0] auto_clear_chan_bit = auto_clear_chan_enable[AUTO_EN_LSB +: NCH];
   wire [NCH-1:0] clear_vec = (i_clear_pin_a_n ? '0 : pin_a_clear_mask)
                              | (i_clear_pin_b_n ? '0 : pin_b_clear_mask)
                              | software_clear_select
                              | (overtemp_clear_source ? auto_clear_chan_bit : '0);

   for (genvar c = 0; c < NCH; c++) begin : g_chan
      assign wr_ch[c] = do_write && in_region(aw_addr, REG_DATA, NCH) && aw_addr[5:2] == 4'(c);
      assign wr_val[c] = DW'(mrg(32'(chan_data[c])));
      dlc_dac_chan u_chan (
         .i_clock(i_clock),
         .i_rst(i_rst),
         .i_wr(wr_ch[c]),
         .i_wdata(wr_val[c]),
         .i_load(load_trigger_bit),
         .i_sync(chan_load_mode[c]),
         .i_clear(clear_vec[c]),
         .i_clear_code(clear_code[c]),
         .o_latch(o_dac_code[c]),
         .o_data(chan_data[c]),
         .o_pending(chan_pending[c])
      );
   end

   // ****************************************
   // alarm conditions, status and pin
   // ****************************************
   // window check per analog input on each new result
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         adc_cond <= '0;
         clr_prev <= '0;
         o_alarm_o <= 1'b0;
         o_alarm_oe <= 1'b0;
      end else begin
         clr_prev <= clear_vec;
         o_alarm_oe <= |(status & alarm_source_enable);
         for (int k = 0; k < NADC; k++) begin
            if (i_adc.valid) begin
               adc_cond[k] <= (i_adc.result[k] > thr[2*k]) || (i_adc.result[k] < thr[2*k+1]);
            end
         end
      end
   end

   wire [NST-1:0] cond = {i_temp.overtemp && local_temp_sensor,
                          i_temp.low[2], i_temp.high[2], i_temp.low[1], i_temp.high[1],
                          i_temp.low[0], i_temp.high[0], adc_cond};
   wire read_clear = ar_hs && i_araddr == OFF_STATUS;
   wire global_alarm_bit = |status;

   dlc_alarm_status u_status (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_cond(cond),
      .i_read_clear(read_clear),
      .i_latch_dis(alarm_latch_disable),
      .o_status(status)
   );

   // ****************************************
   // read data selection
   // ****************************************
   always_comb begin
      rd_ok = 1'b1;
      rd_word = 32'h00000000;
      if (in_region(i_araddr, REG_DATA, NCH)) begin
         rd_word = 32'(o_dac_code[i_araddr[5:2]]);
      end else if (in_region(i_araddr, REG_CODE, NCH)) begin
         rd_word = 32'(clear_code[i_araddr[5:2]]);
      end else if (in_region(i_araddr, REG_THR, NTHR)) begin
         rd_word = 32'(thr[i_araddr[4:2]]);
      end else begin
         case (i_araddr)
            OFF_CTRL: rd_word = 32'({global_alarm_bit, local_temp_sensor, alarm_latch_disable, 1'b0});
            OFF_LOAD_MODE: rd_word = 32'(chan_load_mode);
            OFF_BUF_EN: rd_word = 32'(o_buf_enable);
            OFF_MASK_A: rd_word = 32'(pin_a_clear_mask);
            OFF_MASK_B: rd_word = 32'(pin_b_clear_mask);
            OFF_SW_CLR: rd_word = 32'(software_clear_select);
            OFF_AUTO_SRC: rd_word = 32'(auto_clear_source_sel);
            OFF_AUTO_EN: rd_word = 32'(auto_clear_chan_enable);
            OFF_ALARM_EN: rd_word = 32'(alarm_source_enable);
            OFF_STATUS: rd_word = 32'(status);
            default: rd_ok = 1'b0;
         endcase
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_rst);

   property p_rst_zero;
      $past(i_rst) |-> o_dac_code == '0 && o_buf_enable == '0;
   endproperty
   a_rst_zero: assert property (p_rst_zero) else $error("codes or buffers not zero after reset");

   property p_async_load;
      wr_ch[0] && !chan_load_mode[0] && !clear_vec[0] |=> o_dac_code[0] == $past(wr_val[0]);
   endproperty
   a_async_load: assert property (p_async_load) else $error("async write did not reach latch");

   property p_sync_hold;
      wr_ch[0] && chan_load_mode[0] && !load_trigger_bit && !clear_vec[0] && !clr_prev[0] |=> $stable(o_dac_code[0]);
   endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("sync write changed latch");

   property p_trig_load;
      load_trigger_bit && chan_load_mode[0] && chan_pending[0] && !clear_vec[0] && !clr_prev[0]
         |=> o_dac_code[0] == $past(chan_data[0]) && !chan_pending[0];
   endproperty
   a_trig_load: assert property (p_trig_load) else $error("trigger did not load pending channel");

   property p_trig_skip;
      load_trigger_bit && chan_load_mode[0] && !chan_pending[0] && !clear_vec[0] && !clr_prev[0]
         |=> $stable(o_dac_code[0]);
   endproperty
   a_trig_skip: assert property (p_trig_skip) else $error("untouched channel reloaded");

   property p_clear_in;
      clear_vec[0] |=> o_dac_code[0] == $past(clear_code[0]) ##1 o_dac_code[0] == $past(clear_code[0]) || !$past(clear_vec[0]);
   endproperty
   a_clear_in: assert property (p_clear_in) else $error("cleared channel not at clear code");

   property p_clear_out;
      $fell(clear_vec[0]) && !wr_ch[0] |=> o_dac_code[0] == $past(chan_data[0]);
   endproperty
   a_clear_out: assert property (p_clear_out) else $error("latch not restored after clear");

   property p_pin_mask;
      (!i_clear_pin_a_n && pin_a_clear_mask[0]) || (!i_clear_pin_b_n && pin_b_clear_mask[0]) |-> clear_vec[0];
   endproperty
   a_pin_mask: assert property (p_pin_mask) else $error("masked pin clear missing");

   property p_overtemp;
      status[ST_OVERTEMP] && auto_clear_source_sel[SRC_OVERTEMP] && auto_clear_chan_enable[AUTO_EN_LSB]
         && local_temp_sensor |-> clear_vec[0];
   endproperty
   a_overtemp: assert property (p_overtemp) else $error("overtemp auto clear wrong");

   property p_follow;
      alarm_latch_disable |=> status == $past(cond);
   endproperty
   a_follow: assert property (p_follow) else $error("unlatched status not following");

   property p_sticky;
      !alarm_latch_disable && !read_clear |=> (status & $past(status)) == $past(status);
   endproperty
   a_sticky: assert property (p_sticky) else $error("latched status lost without read");

   property p_pin;
      ##1 o_alarm_oe == $past(|(status & alarm_source_enable)) && !o_alarm_o;
   endproperty
   a_pin: assert property (p_pin) else $error("alarm pin not tracking enabled status");

   property p_window;
      i_adc.valid && i_adc.result[0] > thr[0] |=> adc_cond[0] ##1 status[0] || $past(alarm_latch_disable);
   endproperty
   a_window: assert property (p_window) else $error("high window breach not flagged");

endmodule : dlc_ctrl

// ==== dlc_ctrl_tb_top.sv ====
// testbench: dac load, clear and alarm control
`timescale 1ns/10ps
module dlc_ctrl_tb_top;
   import dlc_pkg::*;
   logic clock = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, pa = 0, pb = 0;
   logic awready, wready, bvalid, arready, rvalid, alarm_o, alarm_oe, pin_a_n, pin_b_n, line;
   logic [1:0] bresp, rresp, resp;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic [NCH-1:0] bufen;
   dlc_adc_t adc = '0;
   dlc_temp_t temp = '0;
   dlc_code_t code;
   int num_errors = 0, comparisons = 0;
   // clock
   always #5 clock = ~clock;
   dlc_ctrl dut (.i_clock(clock), .i_rst(rst), .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
      .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hF), .o_bvalid(bvalid),
      .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
      .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_adc(adc), .i_temp(temp),
      .i_clear_pin_a_n(pin_a_n), .i_clear_pin_b_n(pin_b_n), .o_dac_code(code), .o_buf_enable(bufen),
      .o_alarm_o(alarm_o), .o_alarm_oe(alarm_oe));
   dlc_far_model far (.i_pin_a_low(pa), .i_pin_b_low(pb), .i_alarm_o(alarm_o), .i_alarm_oe(alarm_oe),
      .o_clear_pin_a_n(pin_a_n), .o_clear_pin_b_n(pin_b_n), .o_alarm_line(line));
   // compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // one bus write, address and data offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awvalid <= 1;
      wvalid <= 1;
      awaddr <= a;
      wdata <= d;
      bready <= 1;
      fork
         begin
            do @(posedge clock); while (awready !== 1'b1);
            awvalid <= 0;
         end
         begin
            do @(posedge clock); while (wready !== 1'b1);
            wvalid <= 0;
         end
      join
      do @(posedge clock); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 0;
      @(posedge clock);
   endtask : wr
   // one bus read, compared with the expected word
   task automatic rdr(input logic [7:0] a, input logic [31:0] exp);
      arvalid <= 1;
      araddr <= a;
      rready <= 1;
      do @(posedge clock); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge clock); while (rvalid !== 1'b1);
      rready <= 0;
      resp = rresp;
      chk(rdata, exp);
      @(posedge clock);
   endtask : rdr
   // let registered paths land
   task automatic st;
      repeat (3) @(posedge clock);
   endtask : st
   // one monitoring result on input zero
   task automatic adc_in(input logic [11:0] v);
      adc.result[0] <= v;
      adc.valid <= 1;
      @(posedge clock);
      adc.valid <= 0;
      st;
   endtask : adc_in
   task automatic t_reset;
      chk(32'(|code), 0);
      chk(bufen, 0);
      wr(OFF_BUF_EN, 32'h0FFF);
      chk(resp, RESP_OKAY);
      st;
      chk(bufen, 12'hFFF);
      wr(8'h28, 32'h1);
      chk(resp, RESP_SLVERR);
      rdr(8'h28, 0);
      chk(resp, RESP_SLVERR);
   endtask : t_reset
   task automatic t_async;
      wr(8'h40, 32'h0ABC);
      chk(code[0], 12'hABC);
      rdr(8'h40, 32'h0ABC);
   endtask : t_async
   task automatic t_sync;
      wr(OFF_LOAD_MODE, 32'h0007);
      wr(8'h44, 32'h0123);
      wr(8'h40, 32'h0DEF);
      st;
      chk(code[1], 0);
      chk(code[0], 12'hABC);
      rdr(8'h44, 0);
      wr(OFF_CTRL, 32'h1);
      st;
      chk(code[1], 12'h123);
      chk(code[0], 12'hDEF);
      chk(code[2], 0);
      wr(OFF_CTRL, 32'h1);
      st;
      chk(code[1], 12'h123);
   endtask : t_sync
   task automatic t_clear;
      wr(8'h84, 32'h05A5);
      wr(OFF_SW_CLR, 32'h2);
      st;
      chk(code[1], 12'h5A5);
      wr(OFF_MASK_A, 32'h3);
      pa <= 1;
      wr(OFF_SW_CLR, 32'h0);
      st;
      chk(code[1], 12'h5A5);
      chk(code[0], 0);
      pa <= 0;
      st;
      chk(code[1], 12'h123);
      chk(code[0], 12'hDEF);
      pb <= 1;
      st;
      chk(code[1], 12'h123);
      pb <= 0;
   endtask : t_clear
   task automatic t_alarm;
      wr(OFF_ALARM_EN, 32'h1);
      wr(8'hC0, 32'h0800);
      wr(8'hC4, 32'h0100);
      adc_in(12'h800);
      rdr(OFF_STATUS, 0);
      adc_in(12'h801);
      chk(line, 0);
      rdr(OFF_CTRL, 32'h8);
      adc_in(12'h100);
      chk(line, 0);
      rdr(OFF_STATUS, 32'h1);
      rdr(OFF_STATUS, 0);
      st;
      chk(line, 1);
      wr(OFF_CTRL, 32'h2);
      temp.high[0] <= 1;
      temp.low[2] <= 1;
      st;
      rdr(OFF_STATUS, 32'h210);
      chk(line, 1);
      temp <= '0;
      st;
      rdr(OFF_STATUS, 0);
   endtask : t_alarm
   task automatic t_overtemp;
      wr(OFF_AUTO_SRC, 32'h4);
      wr(OFF_AUTO_EN, 32'h8);
      wr(8'h80, 32'h0777);
      wr(OFF_CTRL, 32'h6);
      temp.overtemp <= 1;
      st;
      chk(code[0], 12'h777);
      rdr(OFF_STATUS, 32'h400);
      wr(OFF_CTRL, 32'h2);
      st;
      chk(code[0], 12'hDEF);
      temp.overtemp <= 0;
   endtask : t_overtemp
   // verdict and end of run
   task automatic wrap_up;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : wrap_up
   // main sequence
   initial begin
      repeat (3) @(posedge clock);
      rst <= 0;
      repeat (2) @(posedge clock);
      t_reset;
      t_async;
      t_sync;
      t_clear;
      t_alarm;
      t_overtemp;
      wrap_up;
   end
   // watchdog against a hang
   initial begin
      #100000;
      num_errors++;
      wrap_up;
   end
endmodule : dlc_ctrl_tb_top

// ==== dlc_dac_chan.sv ====
// module: one dac channel, data register and output latch
`timescale 1ns/10ps
module dlc_dac_chan
   import dlc_pkg::*;
(
   // clock and reset
   input wire logic i_clock,
   input wire logic i_rst,
   // control
   input wire logic i_wr,
   input wire logic [DW-1:0] i_wdata,
   input wire logic i_load,
   input wire logic i_sync,
   input wire logic i_clear,
   input wire logic [DW-1:0] i_clear_code,
   // state
   output logic [DW-1:0] o_latch,
   output logic [DW-1:0] o_data,
   output logic o_pending
);

   logic clear_q;
   wire [DW-1:0] next_data = i_wr ? i_wdata : o_data;

   // data register, pending flag, clear history
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_data <= RST_CODE;
         o_pending <= 1'b0;
         clear_q <= 1'b0;
      end else begin
         o_data <= next_data;
         clear_q <= i_clear;
         if (i_wr) begin
            o_pending <= 1'b1;
         end else if (i_load && i_sync) begin
            o_pending <= 1'b0;
         end
      end
   end

   // output latch: clear wins, then restore, then loads
   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         o_latch <= RST_CODE;
      end else if (i_clear) begin
         o_latch <= i_clear_code;
      end else if (clear_q) begin
         o_latch <= next_data;
      end else if (i_wr && !i_sync) begin
         o_latch <= i_wdata;
      end else if (i_load && i_sync && o_pending) begin
         o_latch <= o_data;
      end
   end

endmodule : dlc_dac_chan

// ==== dlc_far_model.sv ====
// partner: clear pins and the pulled-up alarm line
`timescale 1ns/10ps
module dlc_far_model (
   // commands from the bench
   input wire logic i_pin_a_low,
   input wire logic i_pin_b_low,
   // alarm pin of the block
   input wire logic i_alarm_o,
   input wire logic i_alarm_oe,
   // board side
   output logic o_clear_pin_a_n,
   output logic o_clear_pin_b_n,
   output logic o_alarm_line
);
   // active-low pins, open drain released to the pull-up
   assign o_clear_pin_a_n = ~i_pin_a_low;
   assign o_clear_pin_b_n = ~i_pin_b_low;
   assign o_alarm_line = i_alarm_oe ? i_alarm_o : 1'b1;
endmodule : dlc_far_model

// ==== dlc_pkg.sv ====
// package: constants, types and helpers of the dac load, clear and alarm block
package dlc_pkg;

   // ****************************************
   // sizes
   // ****************************************
   localparam int NCH = 12;
   localparam int DW = 12;
   localparam int NST = 11;
   localparam int NADC = 4;
   localparam int NTHR = 8;

   // ****************************************
   // register byte offsets
   // ****************************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_LOAD_MODE = 8'h04;
   localparam logic [7:0] OFF_BUF_EN = 8'h08;
   localparam logic [7:0] OFF_MASK_A = 8'h0C;
   localparam logic [7:0] OFF_MASK_B = 8'h10;
   localparam logic [7:0] OFF_SW_CLR = 8'h14;
   localparam logic [7:0] OFF_AUTO_SRC = 8'h18;
   localparam logic [7:0] OFF_AUTO_EN = 8'h1C;
   localparam logic [7:0] OFF_ALARM_EN = 8'h20;
   localparam logic [7:0] OFF_STATUS = 8'h24;
   // array regions, selected by address bits 7:6
   localparam logic [1:0] REG_DATA = 2'h1;
   localparam logic [1:0] REG_CODE = 2'h2;
   localparam logic [1:0] REG_THR = 2'h3;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int CTRL_LOAD = 0;
   localparam int CTRL_LDIS = 1;
   localparam int CTRL_LTPWR = 2;
   localparam int CTRL_GLOBAL_ALARM_BIT = 3;
   localparam int ST_TEMP = 4;
   localparam int ST_OVERTEMP = 10;
   localparam int SRC_OVERTEMP = 2;
   localparam int AUTO_EN_LSB = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [11:0] RST_CODE = 12'h000;
   localparam logic [15:0] RST_REG = 16'h0000;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic valid;
      logic [NADC-1:0][DW-1:0] result;
   } dlc_adc_t;
   typedef struct packed {
      logic [2:0] high;
      logic [2:0] low;
      logic overtemp;
   } dlc_temp_t;
   typedef logic [NCH-1:0][DW-1:0] dlc_code_t;

   // byte-lane merge of a bus write into an old value
   function automatic logic [31:0] dlc_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return r;
   endfunction : dlc_merge

endpackage : dlc_pkg
